// ---- design/cre_pkg.sv ----
package cre_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [5:0] CRE_IDX_RX_IRQ_EN = 6'h05;
  localparam logic [5:0] CRE_IDX_BUS_STATE = 6'h06;
  localparam logic [5:0] CRE_IDX_IRQ_STATUS = 6'h08;
  localparam logic [5:0] CRE_IDX_IRQ_MASK = 6'h09;

  // Field positions of receive_interrupt_enable.
  localparam int CRE_WUP_EN_BIT = 7;
  localparam int CRE_CSC_EN_BIT = 6;
  localparam int CRE_RSENS_HI = 5;
  localparam int CRE_RSENS_LO = 4;
  localparam int CRE_TSENS_HI = 3;
  localparam int CRE_TSENS_LO = 2;
  localparam int CRE_OVR_EN_BIT = 1;
  localparam int CRE_RXF_EN_BIT = 0;
  localparam logic [7:0] CRE_RX_IRQ_EN_RST = 8'h00;
  // Bits that initialization mode forces back to reset; the sensitivity fields stay.
  localparam logic [7:0] CRE_INIT_CLEAR_MASK = 8'hC3;

  // Field positions of the bus state register.
  localparam int CRE_RXST_HI = 5;
  localparam int CRE_RXST_LO = 4;
  localparam int CRE_TXST_HI = 3;
  localparam int CRE_TXST_LO = 2;

  // Sticky interrupt status bits; the mask register has the same layout.
  localparam int CRE_IRQ_W = 4;
  localparam int CRE_IRQ_CSC_BIT = 0;
  localparam int CRE_IRQ_WUP_BIT = 1;
  localparam int CRE_IRQ_OVR_BIT = 2;
  localparam int CRE_IRQ_RXF_BIT = 3;
  localparam logic [3:0] CRE_IRQ_STATUS_RST = 4'h0;
  localparam logic [3:0] CRE_IRQ_MASK_RST = 4'h0;

  // Bus state codes.
  localparam logic [1:0] CRE_ST_ACTIVE = 2'h0;
  localparam logic [1:0] CRE_ST_WARNING = 2'h1;
  localparam logic [1:0] CRE_ST_PASSIVE = 2'h2;
  localparam logic [1:0] CRE_ST_BUSOFF = 2'h3;

  // Sensitivity codes.
  localparam logic [1:0] CRE_SENS_NONE = 2'h0;
  localparam logic [1:0] CRE_SENS_BUSOFF = 2'h1;
  localparam logic [1:0] CRE_SENS_PASSIVE = 2'h2;
  localparam logic [1:0] CRE_SENS_ALL = 2'h3;

  // Error counter thresholds.
  localparam logic [8:0] CRE_CNT_WARNING = 9'h060;
  localparam logic [8:0] CRE_CNT_PASSIVE = 9'h080;
  localparam logic [8:0] CRE_CNT_BUSOFF = 9'h100;

endpackage

// ---- design/cre_rx_irq_enable.sv ----
`timescale 1ns/10ps
// Function
// - Byte enable register, index 5, resets zero.
// - Initialization mode holds the four enable bits at reset.
// - Writes only while init request and init acknowledge are both low; reads anytime.
// - Sensitivity fields survive initialization mode.
// - Wake-up enable gates wake-up request.
// - Status-change enable gates error request.
// - Overrun enable gates error request.
// - Receive-full enable gates receiver request.
// - Receiver sensitivity filters status-change flag.
// - Transmitter sensitivity filters status-change flag.
// - Receiver state tracks truth, updates unflagged.
// - Transmitter state tracks truth, updates unflagged.
// - Receiver mirrors bus-off, recovers to active.
// - State coding from error counter thresholds.
// - Counter-derived state change sets status flag.
module cre_rx_irq_enable
  import cre_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int CNT_W = 9
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic wakeup_flag,
  input wire logic overrun_flag,
  input wire logic rx_full_flag,
  input wire logic [CNT_W-1:0] tx_error_count,
  input wire logic [CNT_W-1:0] rx_error_count,
  output logic status_change_flag,
  output logic [1:0] rx_bus_state,
  output logic [1:0] tx_bus_state,
  output logic wakeup_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic irq
);

  logic [7:0] enable_r;
  logic [7:0] enable_nxt;
  logic [3:0] irq_status_r;
  logic [3:0] irq_status_nxt;
  logic [3:0] irq_mask_r;
  logic [3:0] irq_mask_nxt;
  logic [2:0] flag_prev_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_data;
  logic [1:0] rx_state;
  logic [1:0] tx_state;
  logic rx_hit;
  logic tx_hit;

  // Bus decode.
  wire bus_req = cyc_i && stb_i && !ack_r;
  wire [5:0] word_idx = 6'(adr_i[ADR_W-1:2]);
  wire wr_lane0 = bus_req && we_i && sel_i[0];
  wire hit_en = (word_idx == CRE_IDX_RX_IRQ_EN);
  wire hit_bus = (word_idx == CRE_IDX_BUS_STATE);
  wire hit_sts = (word_idx == CRE_IDX_IRQ_STATUS);
  wire hit_msk = (word_idx == CRE_IDX_IRQ_MASK);

  // Initialization mode decode.
  wire init_mode = init_request && init_acknowledge;
  wire run_mode = !init_request && !init_acknowledge;

  // Enable register fields.
  wire wup_en = enable_r[CRE_WUP_EN_BIT];
  wire csc_en = enable_r[CRE_CSC_EN_BIT];
  wire [1:0] rx_sens = enable_r[CRE_RSENS_HI:CRE_RSENS_LO];
  wire [1:0] tx_sens = enable_r[CRE_TSENS_HI:CRE_TSENS_LO];
  wire ovr_en = enable_r[CRE_OVR_EN_BIT];
  wire rxf_en = enable_r[CRE_RXF_EN_BIT];

  // Enable register next value. While only one of the two init bits is set,
  // the register neither accepts writes nor is cleared.
  wire en_write = wr_lane0 && hit_en && run_mode;
  always_comb
  begin
    enable_nxt = enable_r;
    if (init_mode)
    begin
      enable_nxt = enable_r & ~CRE_INIT_CLEAR_MASK;
    end
    else if (en_write)
    begin
      enable_nxt = dat_i[7:0];
    end
  end

  // Live bus states from the error counters.
  wire [8:0] tec = 9'(tx_error_count);
  wire [8:0] rec = 9'(rx_error_count);
  wire tx_off_live = (tec >= CRE_CNT_BUSOFF);

  wire [1:0] tx_live = tx_off_live ? CRE_ST_BUSOFF :
                       (tec >= CRE_CNT_PASSIVE) ? CRE_ST_PASSIVE :
                       (tec >= CRE_CNT_WARNING) ? CRE_ST_WARNING : CRE_ST_ACTIVE;
  wire [1:0] rec_class = (rec >= CRE_CNT_PASSIVE) ? CRE_ST_PASSIVE :
                         (rec >= CRE_CNT_WARNING) ? CRE_ST_WARNING : CRE_ST_ACTIVE;

  // The receiver has no bus-off of its own, so it copies the transmitter's and
  // drops straight to active when the transmitter leaves bus-off.
  wire tx_leaving_off = (tx_state == CRE_ST_BUSOFF) && !tx_off_live;
  wire [1:0] rx_live = tx_off_live ? CRE_ST_BUSOFF :
                       tx_leaving_off ? CRE_ST_ACTIVE : rec_class;

  cre_state_track u_rx_track
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .live_code(rx_live),
    .sens(rx_sens),
    .hold(status_change_flag),
    .state_r(rx_state),
    .change_hit(rx_hit)
  );

  cre_state_track u_tx_track
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .live_code(tx_live),
    .sens(tx_sens),
    .hold(status_change_flag),
    .state_r(tx_state),
    .change_hit(tx_hit)
  );

  // Sticky status. Status change is the flag itself and blocks further state
  // updates until cleared; the other bits catch rising edges of the outside flags.
  wire [3:0] sts_set = {rx_full_flag && !flag_prev_r[2],
                        overrun_flag && !flag_prev_r[1],
                        wakeup_flag && !flag_prev_r[0],
                        rx_hit || tx_hit};
  wire [3:0] sts_clr = (wr_lane0 && hit_sts) ? dat_i[3:0] : 4'h0;

  // A set in the same cycle as its clear wins.
  assign irq_status_nxt = sts_set | (irq_status_r & ~sts_clr);
  assign irq_mask_nxt = (wr_lane0 && hit_msk) ? dat_i[3:0] : irq_mask_r;

  // Read mux; unmapped words read as zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_en)
    begin
      rd_data[7:0] = enable_r;
    end
    else if (hit_bus)
    begin
      rd_data[CRE_RXST_HI:CRE_RXST_LO] = rx_state;
      rd_data[CRE_TXST_HI:CRE_TXST_LO] = tx_state;
    end
    else if (hit_sts)
    begin
      rd_data[3:0] = irq_status_r;
    end
    else if (hit_msk)
    begin
      rd_data[3:0] = irq_mask_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      enable_r <= CRE_RX_IRQ_EN_RST;
      irq_status_r <= CRE_IRQ_STATUS_RST;
      irq_mask_r <= CRE_IRQ_MASK_RST;
      flag_prev_r <= 3'h0;
    end
    else
    begin
      enable_r <= enable_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      flag_prev_r <= {rx_full_flag, overrun_flag, wakeup_flag};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req && !we_i)
      begin
        dat_r <= rd_data;
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign status_change_flag = irq_status_r[CRE_IRQ_CSC_BIT];
  assign rx_bus_state = rx_state;
  assign tx_bus_state = tx_state;

  // Request outputs follow flag and enable combinationally, so they drop
  // in the same cycle the flag or the enable goes away.
  assign wakeup_irq = wup_en && wakeup_flag;
  assign rx_irq = rxf_en && rx_full_flag;
  assign error_irq = (csc_en && status_change_flag) ||
                     (ovr_en && overrun_flag);
  assign irq = |(irq_status_r & irq_mask_r);

endmodule

// ---- design/cre_state_track.sv ----
`timescale 1ns/10ps
module cre_state_track
  import cre_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] live_code,
  input wire logic [1:0] sens,
  input wire logic hold,
  output logic [1:0] state_r,
  output logic change_hit
);

  logic [1:0] state_nxt;
  wire changed = (live_code != state_r);
  wire off_edge = (live_code == CRE_ST_BUSOFF) || (state_r == CRE_ST_BUSOFF);
  wire pas_edge = (live_code[1] != state_r[1]) || off_edge;

  wire sens_pass = (sens == CRE_SENS_ALL) ||
                   ((sens == CRE_SENS_BUSOFF) && off_edge) ||
                   ((sens == CRE_SENS_PASSIVE) && pas_edge);

  // The reported state follows the live state whatever the filter says.
  assign state_nxt = hold ? state_r : live_code;
  assign change_hit = changed && !hold && sens_pass;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= CRE_ST_ACTIVE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

endmodule

// ---- sim/cre_rx_irq_enable_chk.sv ----
`timescale 1ns/10ps
module cre_chk
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic wakeup_flag,
  input wire logic overrun_flag,
  input wire logic rx_full_flag,
  input wire logic status_change_flag,
  input wire logic [1:0] rx_bus_state,
  input wire logic [1:0] tx_bus_state,
  input wire logic wakeup_irq,
  input wire logic error_irq,
  input wire logic rx_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_WAKE_GATE: assert property (wakeup_irq |-> wakeup_flag)
    else $error("wake request without flag");
  AST_RXF_GATE: assert property (rx_irq |-> rx_full_flag)
    else $error("receive request without flag");
  AST_ERR_GATE: assert property (error_irq |-> status_change_flag || overrun_flag)
    else $error("error request without cause");
  AST_INIT_HOLD: assert property ((init_request && init_acknowledge) [*2] |->
    !wakeup_irq && !rx_irq && !error_irq) else $error("enables survive init");
  AST_RX_FROZEN: assert property ($past(status_change_flag) && !$past(srst) |->
    $stable(rx_bus_state)) else $error("rx state moved while flagged");
  AST_TX_FROZEN: assert property ($past(status_change_flag) && !$past(srst) |->
    $stable(tx_bus_state)) else $error("tx state moved while flagged");
  cover property (status_change_flag && error_irq);
  cover property (overrun_flag && error_irq);
  cover property (init_request && init_acknowledge);
endmodule
bind cre_rx_irq_enable cre_chk chk_u (.clk_sys, .srst, .cyc_i, .stb_i, .ack_o, .init_request,
  .init_acknowledge, .wakeup_flag, .overrun_flag, .rx_full_flag, .status_change_flag,
  .rx_bus_state, .tx_bus_state, .wakeup_irq, .error_irq, .rx_irq);

// ---- sim/tb_cre_rx_irq_enable.sv ----
`timescale 1ns/10ps
module tb_cre_rx_irq_enable;
  logic clk_sys = 1'b0, srst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic init_request = 1'b0, init_acknowledge = 1'b0;
  logic wakeup_flag = 1'b0, overrun_flag = 1'b0, rx_full_flag = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [7:0] v;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [8:0] tx_error_count = 9'h000, rx_error_count = 9'h000;
  logic ack_o, status_change_flag, wakeup_irq, error_irq, rx_irq, irq;
  logic [1:0] rx_bus_state, tx_bus_state;
  int miscompares = 0;
  int total_checks = 0;
  cre_rx_irq_enable dut_u (.clk_sys, .srst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .init_request, .init_acknowledge, .wakeup_flag, .overrun_flag,
    .rx_full_flag, .tx_error_count, .rx_error_count, .status_change_flag, .rx_bus_state,
    .tx_bus_state, .wakeup_irq, .error_irq, .rx_irq, .irq);
  always #4 clk_sys = ~clk_sys;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Called right after a rising edge; the request is held until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    @(posedge clk_sys);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    q = dat_o;
    if (n == 20)
    begin
      miscompares++;
      conclude();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h000000, exp});
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask
  initial
  begin
    void'($urandom(78));
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h14, 8'h00);
    rd(8'h3C, 8'h00);
    $display("test reset done");
    repeat (8)
    begin
      v = 8'($urandom);
      wb(1'b1, 8'h14, v);
      rd(8'h14, v);
      wakeup_flag <= 1'($urandom);
      rx_full_flag <= 1'($urandom);
      @(posedge clk_sys);
      chk(wakeup_irq, v[7] & wakeup_flag);
      chk(rx_irq, v[0] & rx_full_flag);
    end
    $display("test random done");
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    wb(1'b1, 8'h14, 8'hFF);
    rd(8'h14, v & 8'h3C);
    init_acknowledge <= 1'b0;
    wb(1'b1, 8'h14, 8'hFF);
    rd(8'h14, v & 8'h3C);
    init_request <= 1'b0;
    $display("test init done");
    wb(1'b1, 8'h14, 8'h7C);
    tx_error_count <= 9'h100;
    settle();
    rd(8'h18, 8'h3C);
    chk(rx_bus_state, 2'h3);
    chk(tx_bus_state, 2'h3);
    chk(status_change_flag, 1'b1);
    chk(error_irq, 1'b1);
    wb(1'b1, 8'h24, 8'h01);
    chk(irq, 1'b1);
    wb(1'b1, 8'h24, 8'h00);
    chk(irq, 1'b0);
    tx_error_count <= 9'h000;
    settle();
    rd(8'h18, 8'h3C);
    // Filters off first, so the clear is not beaten by the pending change.
    wb(1'b1, 8'h14, 8'h40);
    wb(1'b1, 8'h20, 8'h01);
    tx_error_count <= 9'h060;
    rx_error_count <= 9'h060;
    settle();
    rd(8'h18, 8'h14);
    chk(status_change_flag, 1'b0);
    wb(1'b1, 8'h14, 8'h44);
    tx_error_count <= 9'h080;
    settle();
    chk(status_change_flag, 1'b0);
    wb(1'b1, 8'h14, 8'h64);
    rx_error_count <= 9'h080;
    settle();
    chk(status_change_flag, 1'b1);
    wb(1'b1, 8'h14, 8'h02);
    overrun_flag <= 1'b1;
    @(posedge clk_sys);
    chk(error_irq, 1'b1);
    wb(1'b1, 8'h14, 8'h00);
    chk(error_irq, 1'b0);
    $display("test events done");
    conclude();
  end
endmodule
